//--- radio_pkg.sv
package radio_pkg;
    typedef enum logic [2:0] {
        MODE_SLEEP, MODE_STDBY, MODE_FS, MODE_TX, MODE_RX
    } mode_type;
    localparam int         FIFO_DEPTH   = 66;
    localparam int         PTR_W        = 7;
    localparam int         BIT_DIV      = 4;
    localparam logic [3:0] A_CTRL       = 4'h0;
    localparam logic [3:0] A_THRESH     = 4'h1;
    localparam logic [3:0] A_PATCFG     = 4'h2;
    localparam logic [3:0] A_ROUTE_A    = 4'h3;
    localparam logic [3:0] A_STATUS     = 4'h4;
    localparam logic [3:0] A_FIFO       = 4'h5;
    localparam logic [3:0] A_ROUTE_B    = 4'h6;
    localparam logic [3:0] A_PATVAL     = 4'h8;
    localparam int         CTRL_PKT     = 3;
    localparam int         CTRL_SYNC    = 4;
    localparam int         CTRL_BSYNC   = 5;
    localparam int         PAT_TOL_LSB  = 3;
    localparam logic [7:0] CTRL_RESET   = 8'h29;
    localparam logic [7:0] THRESH_RESET = 8'h0f;
    localparam logic [7:0] PATCFG_RESET = 8'h03;
    localparam logic [7:0] PATVAL_RESET = 8'h01;
    localparam logic [7:0] ROUTE_RESET  = 8'h00;
    localparam int         ST_HAS       = 0;
    localparam int         ST_FULL      = 1;
    localparam int         ST_OVF       = 2;
    localparam int         ST_LEVEL     = 3;
    localparam int         ST_SENT      = 4;
    localparam int         ST_MATCH     = 5;
endpackage : radio_pkg

//--- radio_link.sv
interface radio_link;
    import radio_pkg::*;
    logic                nss_n;
    logic                fifo_wr;
    logic                fifo_rd;
    logic                overflow_clear;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    mode_type            mode;
    logic                packet_mode;
    logic                sync_on;
    logic                bit_sync;
    logic [6:0]          threshold;
    logic [2:0]          pat_len;
    logic [2:0]          pat_tol;
    logic [63:0]         pattern_value;
    logic [11:0]         route;
    logic [5:0]          status;
    logic [5:0]          gpio_out;
    logic [5:0]          gpio_oe;
    logic                host_data_out;
    logic                host_data_oe;
    modport dev (input nss_n, fifo_wr, fifo_rd, overflow_clear, wdata, mode,
                 packet_mode, sync_on, bit_sync, threshold, pat_len, pat_tol,
                 pattern_value, route, host_data_out, host_data_oe,
                 output rdata, status, gpio_out, gpio_oe);
    modport ctl (output nss_n, fifo_wr, fifo_rd, overflow_clear, wdata, mode,
                 packet_mode, sync_on, bit_sync, threshold, pat_len, pat_tol,
                 pattern_value, route, host_data_out, host_data_oe,
                 input rdata, status, gpio_out, gpio_oe);
endinterface : radio_link

//--- radio_dev.sv
module radio_dev #(
    parameter int DEPTH = radio_pkg::FIFO_DEPTH,
    parameter int DIV   = radio_pkg::BIT_DIV
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic ce,
    radio_link.dev    link,
    input  wire logic demod_bit,
    input  wire logic demod_valid,
    input  wire logic checksum_good,
    input  wire logic payload_available,
    input  wire logic receive_ready_ind,
    input  wire logic transmit_ready_ind,
    input  wire logic mode_settled,
    input  wire logic synth_locked,
    input  wire logic ref_clock_output,
    input  wire logic auto_sequence_active,
    output logic      mod_bit,
    output logic      mod_strobe
);
    import radio_pkg::*;

    if (DEPTH < 2 || DEPTH > 127 || DIV < 1 || DIV > 255) begin : g_chk
        $error("radio_dev: DEPTH or DIV out of range");
    end

    logic [7:0]       mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, rd_ptr, count, next_count;
    logic [7:0]       div_cnt, sr, rx_acc, rx_byte;
    logic [3:0]       sr_bits;
    logic [2:0]       rx_n;
    logic [63:0]      pat_sh, target, mask;
    mode_type         prev_mode;
    logic rx, tx, full, mode_clear, clear, usr_wr, usr_rd, tx_ld, do_wr;
    logic do_rd, tick, nss_q, has, ovf, level, level_ok, sent, matched;
    logic fresh, hit, rx_byte_valid, emptied, rr_q, pa_q, win, dclk;

    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
        return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign rx   = link.mode == MODE_RX;
    assign tx   = link.mode == MODE_TX;
    assign full = count == PTR_W'(DEPTH);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) prev_mode <= MODE_STDBY;
        else if (ce) prev_mode <= link.mode;
    end
    always_comb begin
        mode_clear = 1'b0;
        if (prev_mode != link.mode) begin
            if (prev_mode == MODE_TX) mode_clear = 1'b1;
            else if (link.mode == MODE_RX && (prev_mode == MODE_SLEEP ||
                     prev_mode == MODE_STDBY)) mode_clear = 1'b1;
            else if (prev_mode == MODE_RX && link.mode == MODE_TX)
                mode_clear = 1'b1;
        end
    end
    assign clear  = mode_clear | link.overflow_clear;
    // The user may not push bytes while the receiver owns the write side
    assign usr_wr = link.fifo_wr & ~rx;
    assign usr_rd = link.fifo_rd & (count != '0);
    assign tx_ld  = tx & link.packet_mode & tick & (sr_bits == 4'h0) &
                    (count != '0) & ~usr_rd;
    assign do_wr  = (usr_wr | rx_byte_valid) & ~full;
    assign do_rd  = usr_rd | tx_ld;
    assign next_count = count + PTR_W'(do_wr) - PTR_W'(do_rd);
    assign emptied = clear | (do_rd & (next_count == '0));

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce) begin
            if (clear) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count  <= '0;
            end else begin
                if (do_wr) wr_ptr <= bump(wr_ptr);
                if (do_rd) rd_ptr <= bump(rd_ptr);
                count <= next_count;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (ce && do_wr && !clear)
            mem[wr_ptr] <= usr_wr ? link.wdata : rx_byte;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) link.rdata <= 8'h00;
        else if (ce && usr_rd) link.rdata <= mem[rd_ptr];
    end

    // A read in flight keeps the flag from its second cycle of select low until select returns high
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nss_q <= 1'b1;
            has   <= 1'b0;
        end else if (ce) begin
            nss_q <= link.nss_n;
            if (clear) has <= 1'b0;
            else if (link.nss_n || nss_q) has <= next_count != '0;
            else if (do_wr) has <= 1'b1;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) ovf <= 1'b0;
        else if (ce) begin
            if ((usr_wr | rx_byte_valid) & full) ovf <= 1'b1;
            else if (link.overflow_clear) ovf <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            level    <= 1'b0;
            level_ok <= 1'b1;
        end else if (ce) begin
            if (clear || next_count == '0) level_ok <= 1'b1;
            else if (next_count == PTR_W'(DEPTH)) level_ok <= 1'b0;
            if (clear) level <= 1'b0;
            else if ((do_wr | do_rd) && level_ok &&
                     next_count != PTR_W'(DEPTH))
                level <= next_count > link.threshold;
        end
    end

    logic [6:0] pat_shift;
    assign tick = div_cnt == 8'(DIV - 1);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) div_cnt <= 8'h00;
        else if (ce) div_cnt <= (tick || !tx) ? 8'h00 : div_cnt + 8'h01;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sr         <= 8'h00;
            sr_bits    <= 4'h0;
            mod_bit    <= 1'b0;
            mod_strobe <= 1'b0;
            sent       <= 1'b0;
        end else if (ce) begin
            mod_strobe <= tx & tick;
            if (!tx || clear) begin
                sr_bits <= 4'h0;
                sent    <= 1'b0;
            end else if (tx_ld) begin
                sr      <= mem[rd_ptr];
                sr_bits <= 4'h8;
                sent    <= 1'b0;
            end else if (tick && !link.packet_mode) begin
                mod_bit <= link.host_data_out;
            end else if (tick && sr_bits != 4'h0) begin
                mod_bit <= sr[7];
                sr      <= {sr[6:0], 1'b0};
                sr_bits <= sr_bits - 4'h1;
                if (sr_bits == 4'h1 && count == '0) sent <= 1'b1;
            end
        end
    end

    // Tolerance counts differing bits over the active pattern window only
    assign pat_shift = 7'd64 - ({1'b0, link.pat_len, 3'b000} + 7'd8);
    assign mask   = ~64'h0 >> pat_shift;
    assign target = link.pattern_value >> pat_shift;
    assign hit    = $countones((pat_sh ^ target) & mask) <=
                    32'(link.pat_tol);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pat_sh  <= 64'h0;
            fresh   <= 1'b0;
            matched <= 1'b0;
        end else if (ce) begin
            fresh <= 1'b0;
            if (rx && link.sync_on && demod_valid &&
                (link.packet_mode || link.bit_sync)) begin
                pat_sh <= {pat_sh[62:0], demod_bit};
                fresh  <= ~matched;
            end
            if (fresh && hit && rx) matched <= 1'b1;
            else if (!rx || emptied) matched <= 1'b0;
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_acc        <= 8'h00;
            rx_n          <= 3'd0;
            rx_byte       <= 8'h00;
            rx_byte_valid <= 1'b0;
        end else if (ce) begin
            rx_byte_valid <= 1'b0;
            if (!matched || !rx || !link.packet_mode) rx_n <= 3'd0;
            else if (demod_valid) begin
                rx_acc <= {rx_acc[6:0], demod_bit};
                rx_n   <= rx_n + 3'd1;
                if (rx_n == 3'd7) begin
                    rx_byte       <= {rx_acc[6:0], demod_bit};
                    rx_byte_valid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rr_q <= 1'b0;
            pa_q <= 1'b0;
            win  <= 1'b0;
            dclk <= 1'b0;
        end else if (ce) begin
            rr_q <= receive_ready_ind;
            pa_q <= payload_available;
            if (receive_ready_ind && !rr_q) win <= 1'b1;
            else if (payload_available && !pa_q) win <= 1'b0;
            dclk <= tx ? tick : (demod_valid & link.bit_sync);
        end
    end

    assign link.status = {matched, sent, level, ovf, full, has};
    logic [5:0] pin_sel;
    for (genvar p = 0; p < 6; p++) begin : g_pin
        logic       sel;
        logic [1:0] code;
        assign code = link.route[2*p +: 2];
        always_comb begin
            sel = 1'b0;
            if (code == 2'b11 && (p == 5 || (p == 0 && !link.packet_mode)))
                sel = mode_settled;
            else if (p == 5 && code == 2'b00 && link.mode != MODE_SLEEP)
                sel = ref_clock_output;
            else if (code == 2'b10 && p == 3 && !link.packet_mode)
                sel = auto_sequence_active;
            else if (!link.packet_mode && (rx || tx)) begin
                if (p == 2) sel = tx ? link.host_data_out : demod_bit;
                else if (p == 1 && code == 2'b00) sel = dclk;
                else if (p == 0 && code == 2'b00)
                    sel = rx ? matched : synth_locked;
                else if (code == 2'b01)
                    sel = rx ? receive_ready_ind : transmit_ready_ind;
            end else if (link.packet_mode) begin
                case (code)
                    2'b00: begin
                        if (p == 3) sel = full;
                        else if (p == 2) sel = has;
                        else if (p == 1) sel = level;
                        else if (p == 0)
                            sel = rx ? checksum_good : (tx & sent);
                        else if (p == 4) sel = tx ? mode_settled : 1'b0;
                    end
                    2'b01: begin
                        if (p == 1) sel = full;
                        else if ((p == 2 || p == 5) && rx)
                            sel = demod_bit & win;
                        else if (p == 0 && rx) sel = payload_available;
                        else if (tx && p != 1) sel = transmit_ready_ind;
                    end
                    2'b10: begin
                        if (p == 1) sel = has;
                        else if (rx && (p == 0 || p == 3)) sel = matched;
                        else if (rx && p == 4) sel = receive_ready_ind;
                    end
                    default: begin
                        if (p == 2) sel = auto_sequence_active;
                        else if (link.mode >= MODE_FS) sel = synth_locked;
                    end
                endcase
            end
        end
        assign pin_sel[p] = sel;
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            link.gpio_out <= 6'h00;
            link.gpio_oe  <= 6'h00;
        end else if (ce) begin
            link.gpio_out <= pin_sel;
            link.gpio_oe  <= ~{3'b000, link.host_data_oe, 2'b00}; // Data pin
        end
    end
endmodule : radio_dev

//--- radio_ctl.sv
module radio_ctl (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    radio_link.ctl          link,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rd_data,
    input  wire logic       tx_serial
);
    import radio_pkg::*;

    logic [7:0] ctrl, thresh, patcfg, route_a, route_b, rd_q;
    logic [7:0] patval [8];
    logic       fifo_q;

    assign link.mode        = mode_type'(ctrl[2:0]);
    assign link.packet_mode = ctrl[CTRL_PKT];
    assign link.sync_on     = ctrl[CTRL_SYNC];
    assign link.bit_sync    = ctrl[CTRL_BSYNC];
    assign link.threshold   = thresh[6:0];
    assign link.pat_len     = patcfg[2:0];
    assign link.pat_tol     = patcfg[PAT_TOL_LSB +: 3];
    assign link.route       = {route_b[3:0], route_a};
    for (genvar i = 0; i < 8; i++) begin : g_pv
        assign link.pattern_value[63-8*i -: 8] = patval[i];
    end
    assign link.wdata       = wr_data;
    assign link.fifo_wr     = wr_en & (addr == A_FIFO);
    // Reads of an empty FIFO are refused here, not sent to the device
    assign link.fifo_rd     = rd_en & (addr == A_FIFO) &
                              link.status[ST_HAS];
    assign link.nss_n       = ~(link.fifo_wr | link.fifo_rd);
    assign link.overflow_clear = wr_en & (addr == A_STATUS) &
                                 wr_data[ST_OVF];
    assign link.host_data_out  = tx_serial;
    assign link.host_data_oe   = (link.mode == MODE_TX) & ~link.packet_mode;
    assign rd_data = fifo_q ? link.rdata : rd_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl    <= CTRL_RESET;
            thresh  <= THRESH_RESET;
            patcfg  <= PATCFG_RESET;
            route_a <= ROUTE_RESET;
            route_b <= ROUTE_RESET;
            for (int i = 0; i < 8; i++) patval[i] <= PATVAL_RESET;
        end else if (ce && wr_en) begin
            case (addr)
                A_CTRL:    ctrl    <= wr_data;
                A_THRESH:  thresh  <= wr_data;
                A_PATCFG:  patcfg  <= wr_data;
                A_ROUTE_A: route_a <= wr_data;
                A_ROUTE_B: route_b <= wr_data;
                default: begin
                    // Zero bytes are kept out of the pattern by software
                    if (addr[3]) patval[addr[2:0]] <= wr_data;
                end
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_q   <= 8'h00;
            fifo_q <= 1'b0;
        end else if (ce) begin
            fifo_q <= link.fifo_rd;
            if (rd_en) begin
                case (addr)
                    A_CTRL:    rd_q <= ctrl;
                    A_THRESH:  rd_q <= thresh;
                    A_PATCFG:  rd_q <= patcfg;
                    A_ROUTE_A: rd_q <= route_a;
                    A_ROUTE_B: rd_q <= route_b;
                    A_STATUS:  rd_q <= {2'b00, link.status};
                    default:   rd_q <= addr[3] ? patval[addr[2:0]] : 8'h00;
                endcase
            end
        end
    end
endmodule : radio_ctl

//--- radio_checker.sv
module radio_checker (
    input logic               sys_clk,
    input logic               nrst,
    input logic               nss_n,
    input logic               fifo_wr,
    input logic               fifo_rd,
    input logic               overflow_clear,
    input radio_pkg::mode_type mode,
    input logic               packet_mode,
    input logic [11:0]        route,
    input logic [5:0]         status,
    input logic [5:0]         gpio_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import radio_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    select_low_a: assert property ((fifo_wr || fifo_rd) |-> !nss_n)
        else $error("select high during fifo strobe");
    full_has_a: assert property (status[ST_FULL] |-> status[ST_HAS])
        else $error("full without bytes");
    write_has_a: assert property ((fifo_wr && mode != MODE_RX &&
        $stable(mode)) |=> status[ST_HAS])
        else $error("byte written but flag low");
    ovf_set_a: assert property ((fifo_wr && status[ST_FULL] &&
        mode != MODE_RX && $stable(mode)) |=> status[ST_OVF] && status[ST_FULL])
        else $error("overflow not flagged");
    clear_empty_a: assert property (overflow_clear |=>
        !status[ST_HAS] && !status[ST_FULL] && !status[ST_OVF])
        else $error("clear left bytes or flag");
    // Two quiet cycles of mode keep any mode-change clear out of the window
    level_hold_a: assert property ((mode == MODE_STDBY &&
        $stable(mode) && $past(mode, 2) == mode && !fifo_wr && !fifo_rd &&
        !overflow_clear) |=> $stable(status[ST_LEVEL]))
        else $error("level moved without access");
    match_drop_a: assert property ((mode != MODE_RX &&
        $past(mode) != MODE_RX) |=> !status[ST_MATCH])
        else $error("match kept outside receive");
    pin_flags_a: assert property ((packet_mode && mode == MODE_STDBY &&
        route[7:0] == 8'h00 && $stable(route) && $stable(mode) &&
        $stable(packet_mode)) ##1 $stable(status) |->
        gpio_out[3:1] == {status[ST_FULL], status[ST_HAS], status[ST_LEVEL]})
        else $error("pins do not show fifo flags");

    cover property (fifo_wr && status[ST_FULL]);
    cover property (status[ST_MATCH]);
    cover property (overflow_clear && status[ST_OVF]);
endmodule : radio_checker

//--- tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import radio_pkg::*;
    logic       sys_clk     = 1'b0;
    logic       nrst        = 1'b0;
    logic [3:0] addr        = 4'h0;
    logic [7:0] wr_data     = 8'h00;
    logic       wr_en       = 1'b0;
    logic       rd_en       = 1'b0;
    logic [7:0] rd_data;
    logic       demod_bit   = 1'b0;
    logic       demod_valid = 1'b0;
    logic [7:0] aux         = 8'h00;
    logic       mod_bit;
    logic       mod_strobe;
    logic [7:0] txbits      = 8'h00;
    logic [7:0] v;
    logic       ce          = 1'b1;
    logic       capture     = 1'b0;
    int         nbits       = 0;
    int         failures    = 0;
    int         compares    = 0;
    logic [2:0] m_from [6]  = '{3'h1, 3'h0, 3'h1, 3'h3, 3'h1, 3'h0};
    logic [2:0] m_to [6]    = '{3'h0, 3'h1, 3'h3, 3'h1, 3'h4, 3'h4};
    logic       m_keep [6]  = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    radio_link link();
    radio_dev #(.DEPTH(FIFO_DEPTH), .DIV(2)) u_radio_dev (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .link(link),
        .demod_bit(demod_bit), .demod_valid(demod_valid),
        .checksum_good(aux[0]), .payload_available(aux[1]),
        .receive_ready_ind(aux[2]), .transmit_ready_ind(aux[3]),
        .mode_settled(aux[4]), .synth_locked(aux[5]),
        .ref_clock_output(aux[6]), .auto_sequence_active(aux[7]),
        .mod_bit(mod_bit), .mod_strobe(mod_strobe));
    radio_ctl u_radio_ctl (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .link(link),
        .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .tx_serial(1'b0));
    radio_checker u_radio_checker (
        .sys_clk(sys_clk), .nrst(nrst), .nss_n(link.nss_n),
        .fifo_wr(link.fifo_wr), .fifo_rd(link.fifo_rd),
        .overflow_clear(link.overflow_clear), .mode(link.mode),
        .packet_mode(link.packet_mode), .route(link.route),
        .status(link.status), .gpio_out(link.gpio_out));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // The first strobe in transmit marks the byte load, not a data bit
    always @(posedge sys_clk) begin
        if (mod_strobe && capture && nbits < 9) begin
            txbits <= {txbits[6:0], mod_bit};
            nbits  <= nbits + 1;
        end
    end

    task automatic give_verdict;
        if (failures == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Each access leaves one idle cycle so no strobe is driven twice per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(negedge sys_clk);
        d = rd_data;
        @(posedge sys_clk);
    endtask : rd
    task automatic rdchk(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d & m, e);
    endtask : rdchk
    task automatic settle;
        repeat (3) @(posedge sys_clk);
    endtask : settle
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            demod_bit <= b[i];
            demod_valid <= 1'b1;
            @(posedge sys_clk);
            demod_valid <= 1'b0;
            @(posedge sys_clk);
        end
        settle;
    endtask : send

    initial begin
        #2_000_000;
        failures++;
        give_verdict;
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rdchk(A_CTRL, 8'hff, CTRL_RESET);
        rdchk(A_THRESH, 8'hff, THRESH_RESET);
        rdchk(A_PATCFG, 8'hff, PATCFG_RESET);
        rdchk(A_ROUTE_A, 8'hff, ROUTE_RESET);
        rdchk(A_PATVAL, 8'hff, PATVAL_RESET);
        ce <= 1'b0;
        wr(A_THRESH, 8'h55);
        ce <= 1'b1;
        rdchk(A_THRESH, 8'hff, THRESH_RESET);
        wr(4'h7, 8'h5a);
        rdchk(4'h7, 8'hff, 8'h00);
        for (int i = 0; i < FIFO_DEPTH; i++) wr(A_FIFO, 8'(i));
        settle;
        rdchk(A_STATUS, 8'h37, 8'h03);
        wr(A_FIFO, 8'hee);
        settle;
        rdchk(A_STATUS, 8'h37, 8'h07);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            rd(A_STATUS, v);
            check({7'h00, v[ST_HAS]}, 8'h01);
            rdchk(A_FIFO, 8'hff, 8'(i));
        end
        rdchk(A_STATUS, 8'h33, 8'h00);
        wr(A_FIFO, 8'h11);
        wr(A_STATUS, 8'h04);
        settle;
        rdchk(A_STATUS, 8'hff, 8'h00);
        wr(A_THRESH, 8'h02);
        wr(A_FIFO, 8'h21);
        wr(A_FIFO, 8'h22);
        settle;
        rdchk(A_STATUS, 8'h08, 8'h00);
        wr(A_FIFO, 8'h23);
        settle;
        rdchk(A_STATUS, 8'h08, 8'h08);
        check({5'h00, link.gpio_out[3:1]}, 8'h03);
        check({2'b00, link.gpio_oe}, 8'h3f);
        wr(A_THRESH, 8'h0a);
        settle;
        rdchk(A_STATUS, 8'h08, 8'h08);
        rdchk(A_FIFO, 8'hff, 8'h21);
        settle;
        rdchk(A_STATUS, 8'h08, 8'h00);
        wr(A_STATUS, 8'h04);
        wr(A_ROUTE_B, 8'h0c);
        for (int k = 0; k < 2; k++) begin
            aux <= {3'h0, k[0], 4'h0};
            settle;
            check({7'h00, link.gpio_out[5]}, 8'(k));
        end
        for (int r = 0; r < 6; r++) begin
            wr(A_CTRL, {5'h04, m_from[r]});
            wr(A_FIFO, 8'h3c);
            wr(A_CTRL, {5'h04, m_to[r]});
            settle;
            rdchk(A_STATUS, 8'h01, {7'h00, m_keep[r]});
            wr(A_CTRL, 8'h21);
            wr(A_STATUS, 8'h04);
        end
        wr(A_CTRL, 8'h29);
        wr(A_FIFO, 8'hb4);
        capture <= 1'b1;
        wr(A_CTRL, 8'h2b);
        v = 8'h00;
        for (int i = 0; i < 40 && v[ST_SENT] !== 1'b1; i++) rd(A_STATUS, v);
        check(txbits, 8'hb4);
        rdchk(A_STATUS, 8'h11, 8'h10);
        wr(A_CTRL, 8'h29);
        wr(A_PATVAL, 8'h1e);
        wr(A_PATCFG, 8'h00);
        wr(A_CTRL, 8'h2c);
        send(8'h1e);
        rdchk(A_STATUS, 8'h20, 8'h00);
        wr(A_CTRL, 8'h3c);
        send(8'h1f);
        rdchk(A_STATUS, 8'h20, 8'h00);
        wr(A_PATCFG, 8'h08);
        send(8'h1f);
        rdchk(A_STATUS, 8'h20, 8'h20);
        wr(A_CTRL, 8'h39);
        settle;
        rdchk(A_STATUS, 8'h20, 8'h00);
        wr(A_PATCFG, 8'h00);
        wr(A_CTRL, 8'h3c);
        send(8'h1e);
        rdchk(A_STATUS, 8'h20, 8'h20);
        wr(A_CTRL, 8'h39);
        wr(A_PATCFG, 8'h01);
        wr(4'h9, 8'h2d);
        wr(A_CTRL, 8'h3c);
        send(8'h1e);
        rdchk(A_STATUS, 8'h20, 8'h00);
        send(8'h2d);
        rdchk(A_STATUS, 8'h20, 8'h20);
        give_verdict;
    end
endmodule : tb
